// ==== logic/ifeag_pkg.sv ====
package ifeag_pkg;

  localparam int WORD_W = 16;
  localparam int NUM_GPR = 8;

  // field positions as vector indices; instruction bit 0 is vector bit 15
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 11;
  localparam int R1_MSB = 10;
  localparam int R1_LSB = 8;
  localparam int R2_MSB = 7;
  localparam int R2_LSB = 5;
  localparam int FN5_MSB = 4;
  localparam int FN5_LSB = 0;
  localparam int FN4_MSB = 3;
  localparam int FN4_LSB = 0;
  localparam int FN2_MSB = 1;
  localparam int FN2_LSB = 0;
  localparam int IND_BIT = 4;
  localparam int RB2_MSB = 7;
  localparam int RB2_LSB = 6;
  localparam int AM1_MSB = 5;
  localparam int AM1_LSB = 4;
  localparam int AM2_MSB = 3;
  localparam int AM2_LSB = 2;
  localparam int WDS_RB_MSB = 6;
  localparam int WDS_RB_LSB = 5;
  localparam int WDS_MSB = 4;
  localparam int WDS_LSB = 0;
  localparam int WDL_MSB = 7;
  localparam int WDL_LSB = 0;
  localparam int PARAM_MSB = 7;
  localparam int PARAM_LSB = 0;
  localparam int SHIFT_MSB = 3;
  localparam int SHIFT_LSB = 0;

  // known group codes and function values
  localparam logic [4:0] OPC_RR_GROUP = 5'h0E;
  localparam logic [4:0] OPC_BAL = 5'h0D;
  localparam logic [4:0] OPC_CB = 5'h18;
  localparam logic [4:0] FUNC_ADD_WORD = 5'h08;
  localparam logic [2:0] FUNC_W5 = 3'h5;
  localparam logic [2:0] FUNC_W4 = 3'h4;
  localparam logic [2:0] FUNC_W2 = 3'h2;

  // address mode codes
  localparam logic [1:0] AM_BASE = 2'h0;
  localparam logic [1:0] AM_POST_INC = 2'h1;
  localparam logic [1:0] AM_APPEND = 2'h2;
  localparam logic [1:0] AM_INDIRECT = 2'h3;

  localparam logic [15:0] CTRL_BLOCK_INC = 16'h0002;
  localparam logic [15:0] EVEN_MASK = 16'hFFFE;
  localparam logic [2:0] NO_BASE = 3'h0;

  typedef enum logic [3:0] {
    FMT_RR, FMT_REG_IMM, FMT_PARAM, FMT_SHIFT, FMT_LONG,
    FMT_ARG4, FMT_ARG5_4, FMT_STOR_IMM, FMT_WD_SHORT, FMT_WD_LONG
  } ifeag_fmt_t;

  typedef enum logic [1:0] {OPK_NONE, OPK_ARG, OPK_DISP} ifeag_opk_t;

  typedef enum logic [1:0] {S_IDLE, S_APPEND, S_EA, S_MEM} ifeag_state_t;

  typedef struct packed {
    ifeag_opk_t kind;
    logic [2:0] base_register_select;
    logic [1:0] address_mode_field;
    logic [15:0] disp;
  } ifeag_opnd_t;

  typedef struct packed {
    ifeag_fmt_t fmt;
    logic [4:0] opcode;
    logic [4:0] func;
    logic [2:0] func_width;
    logic [2:0] first_register_field;
    logic [2:0] second_register_field;
    logic [7:0] param;
    logic [3:0] shift_count;
    logic add_word_op;
    logic imm_word;
    logic [1:0] n_words;
    ifeag_opnd_t [1:0] opnd;
  } ifeag_dec_t;

  typedef struct packed {
    ifeag_fmt_t fmt;
    logic ctrl_block;
    logic [2:0] opnd_bytes;
  } ifeag_hint_t;

  typedef struct packed {
    ifeag_dec_t dec;
    logic [15:0] immediate;
    logic [1:0][15:0] ea;
    logic ctrl_block;
  } ifeag_result_t;

  typedef logic [NUM_GPR-1:0][WORD_W-1:0] ifeag_gpr_t;

  typedef struct packed {
    ifeag_state_t state;
    ifeag_dec_t dec;
    ifeag_hint_t hint;
    logic [1:0][15:0] app;
    logic [1:0] widx;
    logic opi;
    logic [15:0] mem_addr;
    logic [15:0] mem_off;
    logic reg_we;
    logic [2:0] reg_waddr;
    logic [15:0] reg_wdata;
    ifeag_result_t res;
    logic res_valid;
  } ifeag_st_t;

endpackage : ifeag_pkg

// ==== logic/ifeag_field_dec.sv ====
`timescale 1ns/10ps
module ifeag_field_dec
  import ifeag_pkg::*;
(
  // first instruction word and predecode hint
  input wire logic [WORD_W-1:0] i_word,
  input wire ifeag_fmt_t i_fmt_hint,
  // decoded fields
  output ifeag_dec_t o_dec
);

  // known group codes win over the hint
  function automatic ifeag_fmt_t fmt_of(input logic [4:0] opc, input ifeag_fmt_t hint);
    case (opc)
      OPC_RR_GROUP: fmt_of = FMT_RR;
      OPC_BAL: fmt_of = FMT_LONG;
      OPC_CB: fmt_of = FMT_ARG4;
      default: fmt_of = hint;
    endcase
  endfunction : fmt_of

  function automatic ifeag_opnd_t arg_opnd(input logic [2:0] base, input logic [1:0] mode);
    arg_opnd = '0;
    arg_opnd.kind = OPK_ARG;
    arg_opnd.base_register_select = base;
    arg_opnd.address_mode_field = mode;
  endfunction : arg_opnd

  ifeag_dec_t d;
  ifeag_fmt_t fmt;

  always_comb begin
    d = '0;
    fmt = fmt_of(i_word[OPC_MSB:OPC_LSB], i_fmt_hint);
    d.fmt = fmt;
    d.opcode = i_word[OPC_MSB:OPC_LSB];
    case (fmt)
      FMT_RR: begin
        d.first_register_field = i_word[R1_MSB:R1_LSB];
        d.second_register_field = i_word[R2_MSB:R2_LSB];
        d.func = i_word[FN5_MSB:FN5_LSB];
        d.func_width = FUNC_W5;
        d.add_word_op = (d.opcode == OPC_RR_GROUP) && (d.func == FUNC_ADD_WORD);
      end
      FMT_REG_IMM: begin
        d.first_register_field = i_word[R1_MSB:R1_LSB];
        d.param = i_word[PARAM_MSB:PARAM_LSB];
      end
      FMT_PARAM: begin
        d.param = i_word[PARAM_MSB:PARAM_LSB];
      end
      FMT_SHIFT: begin
        d.first_register_field = i_word[R1_MSB:R1_LSB];
        d.shift_count = i_word[SHIFT_MSB:SHIFT_LSB];
      end
      FMT_LONG: begin
        d.second_register_field = i_word[R1_MSB:R1_LSB];
        d.first_register_field = i_word[R2_MSB:R2_LSB];
        d.func = {1'b0, i_word[FN4_MSB:FN4_LSB]};
        d.func_width = FUNC_W4;
        // no base, word is the address, indirect bit picks one storage read
        d.opnd[0] = arg_opnd(NO_BASE, {1'b1, i_word[IND_BIT]});
      end
      FMT_ARG4, FMT_STOR_IMM: begin
        d.second_register_field = i_word[R1_MSB:R1_LSB];
        d.func = {1'b0, i_word[FN4_MSB:FN4_LSB]};
        d.func_width = FUNC_W4;
        d.opnd[0] = arg_opnd({1'b0, i_word[RB2_MSB:RB2_LSB]},
                             i_word[AM1_MSB:AM1_LSB]);
        d.imm_word = (fmt == FMT_STOR_IMM);
      end
      FMT_ARG5_4: begin
        d.opnd[0] = arg_opnd(i_word[R1_MSB:R1_LSB], i_word[AM1_MSB:AM1_LSB]);
        d.opnd[1] = arg_opnd({1'b0, i_word[RB2_MSB:RB2_LSB]},
                             i_word[AM2_MSB:AM2_LSB]);
        d.func = {3'b000, i_word[FN2_MSB:FN2_LSB]};
        d.func_width = FUNC_W2;
      end
      FMT_WD_SHORT: begin
        d.opnd[0].kind = OPK_DISP;
        d.opnd[0].base_register_select = {1'b0, i_word[WDS_RB_MSB:WDS_RB_LSB]};
        d.opnd[0].disp = {10'h000, i_word[WDS_MSB:WDS_LSB], 1'b0};
      end
      FMT_WD_LONG: begin
        d.opnd[0].kind = OPK_DISP;
        d.opnd[0].base_register_select = i_word[R1_MSB:R1_LSB];
        // sign from the top field bit, then doubled
        d.opnd[0].disp = {{7{i_word[WDL_MSB]}}, i_word[WDL_MSB:WDL_LSB], 1'b0};
      end
      default: begin
        d.fmt = fmt;
      end
    endcase
    // one appended word per mode 10 or 11, plus any immediate word
    d.n_words = 2'(d.opnd[0].kind == OPK_ARG && d.opnd[0].address_mode_field[1])
              + 2'(d.opnd[1].kind == OPK_ARG && d.opnd[1].address_mode_field[1])
              + 2'(d.imm_word);
  end

  assign o_dec = d;

endmodule : ifeag_field_dec

// ==== logic/ifeag_top.sv ====
`timescale 1ns/10ps
module ifeag_top
  import ifeag_pkg::*;
#(
  parameter int GPR_COUNT = NUM_GPR
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_ARST_N,
  // instruction words from fetch
  input wire logic I_WORD_VALID,
  input wire logic [WORD_W-1:0] I_WORD,
  input wire ifeag_hint_t I_HINT,
  output logic O_WORD_READY,
  // general registers
  input wire ifeag_gpr_t I_GPR,
  output logic O_REG_WE,
  output logic [2:0] O_REG_WADDR,
  output logic [WORD_W-1:0] O_REG_WDATA,
  // main storage read
  output logic O_MEM_REQ,
  output logic [WORD_W-1:0] O_MEM_ADDR,
  input wire logic I_MEM_ACK,
  input wire logic [WORD_W-1:0] I_MEM_DATA,
  // decoded instruction
  output logic O_RESULT_VALID,
  output ifeag_result_t O_RESULT
);

  if (GPR_COUNT != NUM_GPR) begin : g_bad_gpr
    $error("register file must hold eight registers");
  end

  ifeag_st_t s_ff;
  ifeag_st_t nxt_s;
  ifeag_dec_t dec_w;
  ifeag_opnd_t op;
  logic [15:0] base_val;
  logic [15:0] app_w;
  logic [15:0] inc;
  logic app_idx;
  logic base_zero;
  logic accept;
  logic opnd_done;
  logic [15:0] opnd_ea;

  ifeag_field_dec u_dec (
    .i_word(I_WORD),
    .i_fmt_hint(I_HINT.fmt),
    .o_dec(dec_w)
  );

  assign O_WORD_READY = (s_ff.state == S_IDLE) || (s_ff.state == S_APPEND);
  assign accept = I_WORD_VALID && O_WORD_READY;
  assign op = s_ff.dec.opnd[s_ff.opi];
  assign base_val = I_GPR[op.base_register_select];
  assign base_zero = (op.base_register_select == NO_BASE);
  // second operand's word follows the first operand's word if it has one
  assign app_idx = s_ff.opi && s_ff.dec.opnd[0].kind == OPK_ARG
                   && s_ff.dec.opnd[0].address_mode_field[1];
  assign app_w = s_ff.app[app_idx];
  assign inc = s_ff.hint.ctrl_block ? CTRL_BLOCK_INC : {13'h0000, s_ff.hint.opnd_bytes};

  always_comb begin
    nxt_s = s_ff;
    nxt_s.reg_we = 1'b0;
    nxt_s.res_valid = 1'b0;
    opnd_done = 1'b0;
    opnd_ea = '0;
    case (s_ff.state)
      S_IDLE: begin
        if (I_WORD_VALID) begin
          nxt_s.dec = dec_w;
          nxt_s.hint = I_HINT;
          nxt_s.widx = '0;
          nxt_s.opi = 1'b0;
          nxt_s.res.immediate = '0;
          nxt_s.res.ea = '0;
          // immediate shift and one-word forms go straight on
          nxt_s.state = (dec_w.n_words != 2'h0) ? S_APPEND : S_EA;
        end
      end
      S_APPEND: begin
        if (I_WORD_VALID) begin
          nxt_s.app[s_ff.widx[0]] = I_WORD;
          nxt_s.widx = s_ff.widx + 2'h1;
          if (2'(s_ff.widx + 2'h1) == s_ff.dec.n_words) begin
            nxt_s.state = S_EA;
            // immediate always rides in the last word
            if (s_ff.dec.imm_word) begin
              nxt_s.res.immediate = I_WORD;
            end
          end
        end
      end
      S_EA: begin
        case (op.kind)
          OPK_DISP: begin
            opnd_ea = 16'(base_val + op.disp);
            opnd_done = 1'b1;
          end
          OPK_ARG: begin
            case (op.address_mode_field)
              AM_BASE: begin
                opnd_ea = base_val;
                opnd_done = 1'b1;
              end
              AM_POST_INC: begin
                opnd_ea = base_val;
                nxt_s.reg_we = 1'b1;
                nxt_s.reg_waddr = op.base_register_select;
                nxt_s.reg_wdata = 16'(base_val + inc);
                opnd_done = 1'b1;
              end
              AM_APPEND: begin
                opnd_ea = base_zero ? app_w : 16'(base_val + app_w);
                opnd_done = 1'b1;
              end
              default: begin
                // indirect: one storage read, then the high byte as offset on top when a base is given
                if (base_zero) begin
                  nxt_s.mem_addr = app_w & EVEN_MASK;
                  nxt_s.mem_off = '0;
                end else begin
                  nxt_s.mem_addr = 16'(base_val + {8'h00, app_w[7:0]});
                  nxt_s.mem_off = {8'h00, app_w[15:8]};
                end
                nxt_s.state = S_MEM;
              end
            endcase
          end
          default: begin
            opnd_done = 1'b1;
          end
        endcase
      end
      S_MEM: begin
        if (I_MEM_ACK) begin
          opnd_ea = 16'(I_MEM_DATA + s_ff.mem_off);
          opnd_done = 1'b1;
        end
      end
      default: begin
        nxt_s.state = S_IDLE;
      end
    endcase
    if (opnd_done) begin
      nxt_s.res.ea[s_ff.opi] = opnd_ea;
      if (!s_ff.opi && s_ff.dec.opnd[1].kind != OPK_NONE) begin
        nxt_s.opi = 1'b1;
        nxt_s.state = S_EA;
      end else begin
        nxt_s.state = S_IDLE;
        nxt_s.res.dec = s_ff.dec;
        nxt_s.res.ctrl_block = s_ff.hint.ctrl_block;
        nxt_s.res_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // storage read is held until acknowledged; no timeout, storage must answer
  assign O_MEM_REQ = (s_ff.state == S_MEM);
  assign O_MEM_ADDR = s_ff.mem_addr;
  assign O_REG_WE = s_ff.reg_we;
  assign O_REG_WADDR = s_ff.reg_waddr;
  assign O_REG_WDATA = s_ff.reg_wdata;
  assign O_RESULT_VALID = s_ff.res_valid;
  assign O_RESULT = s_ff.res;

  // helper: appended words taken per instruction (first word not counted), read only by checks
  logic [1:0] seen_ff;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      seen_ff <= '0;
    end else if (accept && s_ff.state == S_IDLE) begin
      seen_ff <= '0;
    end else if (accept) begin
      seen_ff <= seen_ff + 2'h1;
    end
  end

  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_ARST_N);

  a_opcode_taken: assert property (
    (s_ff.state == S_IDLE && I_WORD_VALID)
    |=> (s_ff.dec.opcode == $past(I_WORD[OPC_MSB:OPC_LSB])))
    else $error("opcode not taken from top five bits");

  a_add_word_func: assert property (
    (O_RESULT_VALID && O_RESULT.dec.add_word_op)
    |-> (O_RESULT.dec.func == FUNC_ADD_WORD && O_RESULT.dec.fmt == FMT_RR))
    else $error("add word flagged with wrong function");

  a_rr_registers: assert property (
    (s_ff.state == S_IDLE && I_WORD_VALID && dec_w.fmt == FMT_RR)
    |=> (s_ff.dec.first_register_field == $past(I_WORD[R1_MSB:R1_LSB])
         && s_ff.dec.second_register_field == $past(I_WORD[R2_MSB:R2_LSB])))
    else $error("register form fields misplaced");

  a_word_count: assert property (
    O_RESULT_VALID |-> (seen_ff == O_RESULT.dec.n_words))
    else $error("appended word count mismatch");

  a_shift_no_word: assert property (
    (s_ff.state == S_IDLE && I_WORD_VALID && dec_w.fmt == FMT_SHIFT)
    |=> (s_ff.state == S_EA) ##1 O_RESULT_VALID)
    else $error("immediate shift waited for a word");

  a_disp_sum: assert property (
    (s_ff.state == S_EA && op.kind == OPK_DISP)
    |=> (s_ff.res.ea[$past(s_ff.opi)] == $past(16'(base_val + op.disp))))
    else $error("displacement address wrong");

  a_post_inc: assert property (
    (s_ff.state == S_EA && op.kind == OPK_ARG && op.address_mode_field == AM_POST_INC)
    |=> (O_REG_WE && O_REG_WDATA == $past(16'(base_val + inc))) ##1 !O_REG_WE)
    else $error("base increment wrong");

  a_append_word: assert property (
    (s_ff.state == S_EA && op.kind == OPK_ARG && op.address_mode_field == AM_APPEND
     && base_zero)
    |=> (s_ff.res.ea[$past(s_ff.opi)] == $past(app_w)))
    else $error("appended word not used as address");

  a_indirect_even: assert property (
    (O_MEM_REQ && base_zero) |-> !O_MEM_ADDR[0])
    else $error("indirect read at odd address");

  a_base_direct: assert property (
    (s_ff.state == S_EA && op.kind == OPK_ARG && op.address_mode_field == AM_BASE)
    |=> (s_ff.res.ea[$past(s_ff.opi)] == $past(base_val)))
    else $error("base register not used as address");

  // storage may stall; request and address must hold until the answer
  a_mem_hold: assert property (
    (O_MEM_REQ && !I_MEM_ACK) |=> (O_MEM_REQ && $stable(O_MEM_ADDR)))
    else $error("storage request dropped before answer");

  a_indirect_sum: assert property (
    (O_MEM_REQ && I_MEM_ACK)
    |=> (s_ff.res.ea[$past(s_ff.opi)] == $past(16'(I_MEM_DATA + s_ff.mem_off))))
    else $error("indirect address sum wrong");

endmodule : ifeag_top

// ==== test/ifeag_far_model.sv ====
`timescale 1ns/10ps
module ifeag_far_model
  import ifeag_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // storage read side
  input wire logic i_mem_req,
  input wire logic [WORD_W-1:0] i_mem_addr,
  output logic o_mem_ack,
  output logic [WORD_W-1:0] o_mem_data,
  // register file side
  input wire logic i_reg_we,
  input wire logic [2:0] i_reg_waddr,
  input wire logic [WORD_W-1:0] i_reg_wdata,
  output ifeag_gpr_t o_gpr
);
  logic [WORD_W-1:0] regs [NUM_GPR];
  int delay_cycles = 0;
  int wait_cnt;
  logic [WORD_W-1:0] noise_ff;
  // storage word is the inverted address, so every read is predictable
  assign o_mem_ack = i_mem_req && (wait_cnt >= delay_cycles);
  // no stale data outside the ack cycle: an unknown would settle by luck
  assign o_mem_data = o_mem_ack ? ~i_mem_addr : noise_ff;
  always_comb begin
    for (int i = 0; i < NUM_GPR; i++) begin
      o_gpr[i] = regs[i];
    end
  end
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_cnt <= 0;
      noise_ff <= 16'h5A5A;
    end else begin
      noise_ff <= noise_ff + 16'h3C71;
      wait_cnt <= (o_mem_ack || !i_mem_req) ? 0 : wait_cnt + 1;
      if (i_reg_we) begin
        regs[i_reg_waddr] <= i_reg_wdata;
      end
    end
  end
  task automatic set_reg(input int idx, input logic [WORD_W-1:0] val);
    regs[idx] = val;
  endtask : set_reg
endmodule : ifeag_far_model

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import ifeag_pkg::*;
;
  logic clk, arst_n, word_valid, word_ready, reg_we, mem_req, mem_ack, res_valid;
  logic [15:0] word, reg_wdata, mem_addr, mem_data, a, e;
  logic [2:0] reg_waddr;
  logic [1:0] rb, am;
  ifeag_hint_t hint;
  ifeag_gpr_t gpr;
  ifeag_result_t res_o, res;
  logic [15:0] gv [8];
  logic [1:0] cb_rb [5] = '{2'h1, 2'h0, 2'h3, 2'h0, 2'h2};
  logic [1:0] cb_am [5] = '{AM_BASE, AM_APPEND, AM_APPEND, AM_INDIRECT, AM_INDIRECT};
  logic [15:0] cb_w [5] = '{16'h0000, 16'h0246, 16'h0100, 16'h0050, 16'h2577};
  int n_mismatch = 0;
  int n_tests = 0;

  ifeag_top i_dut (.I_CLOCK(clk), .I_ARST_N(arst_n), .I_WORD_VALID(word_valid),
    .I_WORD(word), .I_HINT(hint), .O_WORD_READY(word_ready), .I_GPR(gpr),
    .O_REG_WE(reg_we), .O_REG_WADDR(reg_waddr), .O_REG_WDATA(reg_wdata),
    .O_MEM_REQ(mem_req), .O_MEM_ADDR(mem_addr), .I_MEM_ACK(mem_ack),
    .I_MEM_DATA(mem_data), .O_RESULT_VALID(res_valid), .O_RESULT(res_o));
  ifeag_far_model i_far (.i_clock(clk), .i_arst_n(arst_n), .i_mem_req(mem_req),
    .i_mem_addr(mem_addr), .o_mem_ack(mem_ack), .o_mem_data(mem_data),
    .i_reg_we(reg_we), .i_reg_waddr(reg_waddr), .i_reg_wdata(reg_wdata), .o_gpr(gpr));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // words are held until an edge with ready high takes them
  task automatic run(input logic [15:0] w0, w1, w2, input int n, input ifeag_fmt_t f,
      input logic cb, input logic [2:0] nb);
    logic [2:0][15:0] w;
    int k;
    w = {w2, w1, w0};
    for (int i = 0; i <= n; i++) begin
      word_valid <= 1'b1;
      word <= w[i];
      hint <= '{fmt: f, ctrl_block: cb, opnd_bytes: nb};
      k = 0;
      @(negedge clk);
      while (word_ready !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      if (k >= 20) chk("word_ready", 16'h0001, 16'h0000);
      @(posedge clk);
    end
    word_valid <= 1'b0;
    k = 0;
    @(negedge clk);
    while (res_valid !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    if (k >= 40) chk("result_valid", 16'h0001, 16'h0000);
    res = res_o;
    @(posedge clk);
  endtask : run

  task automatic ea_case(input logic [15:0] w0, w1, input int n, input ifeag_fmt_t f,
      input logic [15:0] e0);
    run(w0, w1, 16'h0000, n, f, 1'b0, 3'h2);
    chk("ea0", e0, res.ea[0]);
    chk("n_words", 16'(n), 16'(res.dec.n_words));
  endtask : ea_case

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    arst_n = 1'b0;
    word_valid = 1'b0;
    word = 16'h0000;
    hint = '0;
    gv = '{16'hFFF0, 16'h0080, 16'h0500, 16'h0800, 16'h0100, 16'hFFF0, 16'h0086, 16'h1000};
    for (int i = 0; i < 8; i++) i_far.set_reg(i, gv[i]);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("ready_in_reset", 16'h0001, 16'(word_ready));
    chk("valid_in_reset", 16'h0000, 16'(res_valid));
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    run({5'h0E, 3'd3, 3'd5, 5'h08}, 16'h0, 16'h0, 0, FMT_RR, 1'b0, 3'h2);
    chk("opcode", 16'h000E, 16'(res.dec.opcode));
    chk("func", 16'h0008, 16'(res.dec.func));
    chk("add_word", 16'h0001, 16'(res.dec.add_word_op));
    chk("func_w5", 16'(FUNC_W5), 16'(res.dec.func_width));
    chk("rr_r1", 16'h0003, 16'(res.dec.first_register_field));
    chk("rr_r2", 16'h0005, 16'(res.dec.second_register_field));
    ea_case({5'h0D, 3'd2, 3'd4, 1'b0, 4'h3}, 16'h1234, 1, FMT_LONG, 16'h1234);
    chk("bal_r2", 16'h0002, 16'(res.dec.second_register_field));
    chk("bal_r1", 16'h0004, 16'(res.dec.first_register_field));
    i_far.delay_cycles = 3;
    ea_case({5'h0D, 3'd2, 3'd4, 1'b1, 4'h3}, 16'h0061, 1, FMT_LONG, ~16'h0060);
    for (int i = 0; i < 5; i++) begin
      rb = cb_rb[i];
      am = cb_am[i];
      a = cb_w[i];
      i_far.delay_cycles = 3 * (i % 2);
      run({5'h18, 3'd6, rb, am, 4'h9}, a, 16'h0, int'(am[1]), FMT_ARG4, 1'b0, 3'h2);
      case (am)
        AM_BASE: e = gv[rb];
        AM_APPEND: e = (rb == 2'h0) ? a : 16'(gv[rb] + a);
        default: e = (rb == 2'h0) ? ~a : 16'(~(gv[rb] + {8'h0, a[7:0]}) + {8'h0, a[15:8]});
      endcase
      chk("cb_ea", e, res.ea[0]);
      chk("cb_words", 16'(am[1]), 16'(res.dec.n_words));
      chk("cb_func", 16'h0009, 16'(res.dec.func));
      chk("cb_reg", 16'h0006, 16'(res.dec.second_register_field));
      chk("cb_base", 16'(rb), 16'(res.dec.opnd[0].base_register_select));
      chk("cb_mode", 16'(am), 16'(res.dec.opnd[0].address_mode_field));
    end
    ea_case({5'h03, 4'h0, 2'd0, 5'd31}, 16'h0, 0, FMT_WD_SHORT, 16'h002E);
    ea_case({5'h03, 4'h0, 2'd3, 5'd4}, 16'h0, 0, FMT_WD_SHORT, 16'h0808);
    ea_case({5'h04, 3'd6, 8'hE9}, 16'h0, 0, FMT_WD_LONG, 16'h0058);
    ea_case({5'h04, 3'd7, 8'h7F}, 16'h0, 0, FMT_WD_LONG, 16'h10FE);
    run({5'h05, 3'd7, 2'd2, AM_APPEND, AM_APPEND, 2'h1}, 16'h0010, 16'h0020, 2, FMT_ARG5_4,
      1'b0, 3'h2);
    chk("two_ea0", 16'h1010, res.ea[0]);
    chk("two_ea1", 16'h0520, res.ea[1]);
    chk("two_words", 16'h0002, 16'(res.dec.n_words));
    chk("func_w2", 16'(FUNC_W2), 16'(res.dec.func_width));
    run({5'h06, 3'd1, 8'hA7}, 16'h0, 16'h0, 0, FMT_PARAM, 1'b0, 3'h2);
    chk("param", 16'h00A7, 16'(res.dec.param));
    run({5'h09, 3'd5, 8'h3C}, 16'h0, 16'h0, 0, FMT_REG_IMM, 1'b0, 3'h2);
    chk("imm_opcode", 16'h0009, 16'(res.dec.opcode));
    chk("imm_byte", 16'h003C, 16'(res.dec.param));
    chk("imm_reg", 16'h0005, 16'(res.dec.first_register_field));
    chk("imm_words", 16'h0000, 16'(res.dec.n_words));
    run({5'h07, 7'h00, 4'hB}, 16'h0, 16'h0, 0, FMT_SHIFT, 1'b0, 3'h2);
    chk("shift", 16'h000B, 16'(res.dec.shift_count));
    chk("shift_words", 16'h0000, 16'(res.dec.n_words));
    run({5'h08, 11'h000}, 16'hBEEF, 16'h0, 1, FMT_STOR_IMM, 1'b0, 3'h2);
    chk("immediate", 16'hBEEF, res.immediate);
    // post-increment by operand size, or two for a control block
    for (int i = 0; i < 4; i++) begin
      i_far.set_reg(1, 16'h0080);
      run({5'h18, 3'd0, 2'd1, AM_POST_INC, 4'h9}, 16'h0, 16'h0, 0, FMT_ARG4, 1'(i == 3),
        (i == 3) ? 3'h4 : 3'(1 << i));
      @(negedge clk);
      chk("inc_ea", 16'h0080, res.ea[0]);
      chk("inc_reg", (i == 3) ? 16'h0082 : 16'(16'h0080 + (1 << i)), i_far.regs[1]);
      chk("ctrl_block", 16'(i == 3), 16'(res.ctrl_block));
      @(posedge clk);
    end
    end_of_test();
  end
endmodule : tb_top
